// ===== rtl/tmcc_pkg.sv
package tmcc_pkg;
   // Register byte offsets
   localparam logic [11:0] TMCC_CFG_OFF = 12'h000;
   localparam logic [11:0] TMCC_AMODE_OFF = 12'h004;
   localparam logic [11:0] TMCC_BMODE_OFF = 12'h008;
   localparam logic [11:0] TMCC_CTL_OFF = 12'h00C;
   localparam logic [11:0] TMCC_STAT_OFF = 12'h010;
   localparam int TMCC_ADDR_W = 12;
   // Writable field masks
   localparam logic [31:0] TMCC_CFG_MASK = 32'h0000_0007;
   localparam logic [31:0] TMCC_MODE_MASK = 32'h0000_000F;
   localparam logic [31:0] TMCC_CTL_MASK = 32'h0000_0F60;
   localparam logic [31:0] TMCC_RST_VAL = 32'h0000_0000;
   // Field positions
   localparam int TMCC_AMS_BIT = 3;
   localparam int TMCC_CMR_BIT = 2;
   localparam int TMCC_EVT_LSB = 10;
   localparam int TMCC_STALL_BIT = 9;
   localparam int TMCC_EN_BIT = 8;
   localparam int TMCC_PWML_BIT = 6;
   localparam int TMCC_OTE_BIT = 5;
   // Encodings
   localparam logic [2:0] TMCC_CFG_FULL = 3'h0;
   localparam logic [2:0] TMCC_CFG_RTC = 3'h1;
   localparam logic [1:0] TMCC_MODE_ONESHOT = 2'h1;
   localparam logic [1:0] TMCC_MODE_PERIODIC = 2'h2;
   localparam logic [1:0] TMCC_MODE_CAPTURE = 2'h3;
   localparam logic [1:0] TMCC_EVT_RISE = 2'h0;
   localparam logic [1:0] TMCC_EVT_FALL = 2'h1;
   localparam logic [1:0] TMCC_EVT_BOTH = 2'h3;
   localparam logic [1:0] TMCC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TMCC_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {TMCC_WID_FULL, TMCC_WID_RTC, TMCC_WID_SPLIT, TMCC_WID_RSVD} tmcc_width_t;
   typedef enum logic [2:0] {TMCC_OP_OFF, TMCC_OP_ONESHOT, TMCC_OP_PERIODIC, TMCC_OP_CAPCOUNT,
      TMCC_OP_CAPTIME, TMCC_OP_PWM} tmcc_op_t;
endpackage

// ===== rtl/tmcc_top.sv
// Contract
// - Second capture style 0 selects edge counting, 1 selects edge time stamping in capture operation.
// - Second mode field decodes 1 one-shot, 2 periodic, 3 capture; 0 is reserved.
// - In split configuration the second mode field selects the second half-width timer mode.
// - In full-width configuration the second mode register is ignored and the first timer mode is used.
// - Second event field selects 0 rising, 1 falling, 3 both edges; 2 is reserved.
// - While the debugger halts the processor the second timer freezes if its freeze bit is 1.
// - The freeze bit is ignored while the processor runs normally.
// - Second run enable 1 starts counting or arms capture per width configuration; 0 disables it.
// - First timer PWM output passes unchanged when the invert bit is 0 and inverted when 1.
// - First timer event reaches the converter trigger only when the trigger enable bit is 1.
// - Width configuration 0 is full-width, 1 is real-time counter, 4 to 7 are split half-width.
`timescale 1ns/10ps
module tmcc_top
   import tmcc_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // AXI4-Lite write
   input wire logic [tmcc_pkg::TMCC_ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [tmcc_pkg::TMCC_ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Processor and timer datapath
   input wire logic DEBUG_HALT,
   input wire logic FIRST_PWM_RAW,
   input wire logic FIRST_EVENT,
   input wire logic SECOND_EDGE_IN,
   // Decoded controls
   output logic FIRST_PWM_OUT,
   output logic ADC_TRIGGER,
   output logic SECOND_RUN,
   output logic SECOND_EDGE_EVENT,
   output logic [2:0] SECOND_OP,
   output logic [1:0] WIDTH_MODE
);
   import tmcc_pkg::*;

   logic [31:0] cfg_reg, amode_reg, bmode_reg, ctl_reg;
   logic [TMCC_ADDR_W-1:0] awaddr_reg;
   logic aw_held_reg, w_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic edge_s1_reg, edge_s2_reg, edge_s3_reg;
   logic halt_s1_reg, halt_s2_reg;
   logic pwm_s1_reg, pwm_s2_reg;
   logic fev_s1_reg, fev_s2_reg;
   tmcc_width_t width;
   tmcc_op_t op_next;
   logic [3:0] eff_mode;
   logic do_write;
   logic wr_hit;
   logic freeze;
   logic rise, fall;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [31:0] mask);
      logic [31:0] be;
      be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & mask;
      merge = (old & ~be) | (wd & be);
   endfunction

   function automatic tmcc_width_t decode_width(input logic [2:0] cfg);
      if (cfg == TMCC_CFG_FULL) begin
         decode_width = TMCC_WID_FULL;
      end else if (cfg == TMCC_CFG_RTC) begin
         decode_width = TMCC_WID_RTC;
      end else if (cfg[2]) begin
         decode_width = TMCC_WID_SPLIT;
      end else begin
         decode_width = TMCC_WID_RSVD;
      end
   endfunction

   // Write channel: address and data accepted in either order, held until response
   assign AWREADY = !aw_held_reg && !BVALID;
   assign WREADY = !w_held_reg && !BVALID;
   assign do_write = aw_held_reg && w_held_reg && !BVALID;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= AWADDR;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_held_reg <= 1'b1;
            wdata_reg <= WDATA;
            wstrb_reg <= WSTRB;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      unique case (awaddr_reg)
         TMCC_CFG_OFF, TMCC_AMODE_OFF, TMCC_BMODE_OFF, TMCC_CTL_OFF: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         BVALID <= 1'b0;
         BRESP <= TMCC_RESP_OKAY;
      end else if (do_write) begin
         BVALID <= 1'b1;
         BRESP <= wr_hit ? TMCC_RESP_OKAY : TMCC_RESP_SLVERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // Masks keep reserved bits, bit 7 among them, at zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg <= TMCC_RST_VAL;
         amode_reg <= TMCC_RST_VAL;
         bmode_reg <= TMCC_RST_VAL;
         ctl_reg <= TMCC_RST_VAL;
      end else if (do_write) begin
         if (awaddr_reg == TMCC_CFG_OFF) begin
            cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg, TMCC_CFG_MASK);
         end
         if (awaddr_reg == TMCC_AMODE_OFF) begin
            amode_reg <= merge(amode_reg, wdata_reg, wstrb_reg, TMCC_MODE_MASK);
         end
         if (awaddr_reg == TMCC_BMODE_OFF) begin
            bmode_reg <= merge(bmode_reg, wdata_reg, wstrb_reg, TMCC_MODE_MASK);
         end
         if (awaddr_reg == TMCC_CTL_OFF) begin
            ctl_reg <= merge(ctl_reg, wdata_reg, wstrb_reg, TMCC_CTL_MASK);
         end
      end
   end

   // Read channel: one-cycle answer, data registered
   assign ARREADY = !RVALID;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= TMCC_RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RRESP <= TMCC_RESP_OKAY;
         unique case (ARADDR)
            TMCC_CFG_OFF: RDATA <= cfg_reg;
            TMCC_AMODE_OFF: RDATA <= amode_reg;
            TMCC_BMODE_OFF: RDATA <= bmode_reg;
            TMCC_CTL_OFF: RDATA <= ctl_reg;
            TMCC_STAT_OFF: RDATA <= {24'h000000, 1'b0, SECOND_OP, WIDTH_MODE, SECOND_RUN, freeze};
            default: begin
               RDATA <= '0;
               RRESP <= TMCC_RESP_SLVERR;
            end
         endcase
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // Pin-side inputs from outside the clock domain pass two flops first
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         edge_s1_reg <= 1'b0;
         edge_s2_reg <= 1'b0;
         edge_s3_reg <= 1'b0;
         halt_s1_reg <= 1'b0;
         halt_s2_reg <= 1'b0;
         pwm_s1_reg <= 1'b0;
         pwm_s2_reg <= 1'b0;
         fev_s1_reg <= 1'b0;
         fev_s2_reg <= 1'b0;
      end else begin
         edge_s1_reg <= SECOND_EDGE_IN;
         edge_s2_reg <= edge_s1_reg;
         edge_s3_reg <= edge_s2_reg;
         halt_s1_reg <= DEBUG_HALT;
         halt_s2_reg <= halt_s1_reg;
         pwm_s1_reg <= FIRST_PWM_RAW;
         pwm_s2_reg <= pwm_s1_reg;
         fev_s1_reg <= FIRST_EVENT;
         fev_s2_reg <= fev_s1_reg;
      end
   end

   assign width = decode_width(cfg_reg[2:0]);
   // Full width takes the first timer's mode, split takes the second's
   assign eff_mode = (width == TMCC_WID_SPLIT) ? bmode_reg[3:0] : amode_reg[3:0];
   // Freeze only while halted and only if requested
   assign freeze = halt_s2_reg && ctl_reg[TMCC_STALL_BIT];
   assign rise = edge_s2_reg && !edge_s3_reg;
   assign fall = !edge_s2_reg && edge_s3_reg;

   always_comb begin
      op_next = TMCC_OP_OFF;
      if (ctl_reg[TMCC_EN_BIT] && (width == TMCC_WID_FULL || width == TMCC_WID_SPLIT)) begin
         unique case (eff_mode[1:0])
            TMCC_MODE_ONESHOT: op_next = TMCC_OP_ONESHOT;
            TMCC_MODE_PERIODIC: op_next = eff_mode[TMCC_AMS_BIT] ? TMCC_OP_PWM : TMCC_OP_PERIODIC;
            TMCC_MODE_CAPTURE: op_next = eff_mode[TMCC_CMR_BIT] ? TMCC_OP_CAPTIME : TMCC_OP_CAPCOUNT;
            default: op_next = TMCC_OP_OFF;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SECOND_OP <= TMCC_OP_OFF;
         WIDTH_MODE <= 2'h0;
         SECOND_RUN <= 1'b0;
      end else begin
         SECOND_OP <= op_next;
         WIDTH_MODE <= width;
         SECOND_RUN <= (op_next != TMCC_OP_OFF) && !freeze;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SECOND_EDGE_EVENT <= 1'b0;
         FIRST_PWM_OUT <= 1'b0;
         ADC_TRIGGER <= 1'b0;
      end else begin
         unique case (ctl_reg[TMCC_EVT_LSB +: 2])
            TMCC_EVT_RISE: SECOND_EDGE_EVENT <= rise;
            TMCC_EVT_FALL: SECOND_EDGE_EVENT <= fall;
            TMCC_EVT_BOTH: SECOND_EDGE_EVENT <= rise || fall;
            default: SECOND_EDGE_EVENT <= 1'b0;
         endcase
         FIRST_PWM_OUT <= pwm_s2_reg ^ ctl_reg[TMCC_PWML_BIT];
         ADC_TRIGGER <= fev_s2_reg && ctl_reg[TMCC_OTE_BIT];
      end
   end

   // Assertions
   property p_pwm_inv;
      @(posedge CLK) disable iff (!RST_N) 1'b1 |=> FIRST_PWM_OUT == ($past(pwm_s2_reg) ^ $past(ctl_reg[TMCC_PWML_BIT]));
   endproperty
   a_pwm_inv: assert property (p_pwm_inv) else $error("pwm invert wrong");
   property p_adc_gate;
      @(posedge CLK) disable iff (!RST_N) !ctl_reg[TMCC_OTE_BIT] ##1 !ctl_reg[TMCC_OTE_BIT] |-> !ADC_TRIGGER;
   endproperty
   a_adc_gate: assert property (p_adc_gate) else $error("adc trigger leaked");
   property p_freeze;
      @(posedge CLK) disable iff (!RST_N) (halt_s2_reg && ctl_reg[TMCC_STALL_BIT]) |=> !SECOND_RUN;
   endproperty
   a_freeze: assert property (p_freeze) else $error("not frozen while halted");
   property p_nohalt;
      @(posedge CLK) disable iff (!RST_N) (!halt_s2_reg && op_next != TMCC_OP_OFF) |=> SECOND_RUN;
   endproperty
   a_nohalt: assert property (p_nohalt) else $error("stall applied while running");
   property p_disable;
      @(posedge CLK) disable iff (!RST_N) !ctl_reg[TMCC_EN_BIT] |=> SECOND_OP == TMCC_OP_OFF && !SECOND_RUN;
   endproperty
   a_disable: assert property (p_disable) else $error("runs while disabled");
   property p_full_uses_first;
      @(posedge CLK) disable iff (!RST_N)
         (width == TMCC_WID_FULL && ctl_reg[TMCC_EN_BIT] && amode_reg[1:0] == TMCC_MODE_ONESHOT)
         |=> SECOND_OP == TMCC_OP_ONESHOT;
   endproperty
   a_full_uses_first: assert property (p_full_uses_first) else $error("full width mode source wrong");
   property p_split_capture;
      @(posedge CLK) disable iff (!RST_N)
         (width == TMCC_WID_SPLIT && ctl_reg[TMCC_EN_BIT] && bmode_reg[2:0] == 3'h3)
         |=> SECOND_OP == TMCC_OP_CAPCOUNT;
   endproperty
   a_split_capture: assert property (p_split_capture) else $error("split capture decode wrong");
   property p_timestamp;
      @(posedge CLK) disable iff (!RST_N)
         (op_next != TMCC_OP_OFF && eff_mode[1:0] == TMCC_MODE_CAPTURE && eff_mode[TMCC_CMR_BIT])
         |=> SECOND_OP == TMCC_OP_CAPTIME;
   endproperty
   a_timestamp: assert property (p_timestamp) else $error("capture style wrong");
   property p_reserved_mode;
      @(posedge CLK) disable iff (!RST_N) eff_mode[1:0] == 2'h0 |=> SECOND_OP == TMCC_OP_OFF;
   endproperty
   a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode ran");
   property p_rsvd_zero;
      @(posedge CLK) disable iff (!RST_N) (ctl_reg & ~TMCC_CTL_MASK) == 32'h0000_0000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bit set");
   property p_rise_evt;
      @(posedge CLK) disable iff (!RST_N)
         (ctl_reg[TMCC_EVT_LSB +: 2] == TMCC_EVT_RISE && fall) |=> !SECOND_EDGE_EVENT;
   endproperty
   a_rise_evt: assert property (p_rise_evt) else $error("falling edge counted in rising mode");
   property p_rtc_off;
      @(posedge CLK) disable iff (!RST_N) cfg_reg[2:0] == TMCC_CFG_RTC |=> SECOND_OP == TMCC_OP_OFF;
   endproperty
   a_rtc_off: assert property (p_rtc_off) else $error("timer runs in counter configuration");
   c_write: cover property (@(posedge CLK) disable iff (!RST_N) BVALID && BREADY);
   c_pwm: cover property (@(posedge CLK) disable iff (!RST_N) SECOND_OP == TMCC_OP_PWM);
   c_freeze: cover property (@(posedge CLK) disable iff (!RST_N) freeze && ctl_reg[TMCC_EN_BIT]);
   c_both: cover property (@(posedge CLK) disable iff (!RST_N) SECOND_EDGE_EVENT && fall);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import tmcc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic halt = 1'b0;
   logic pwm_raw = 1'b0;
   logic first_ev = 1'b0;
   logic edge_in = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pwm_out, adc_trig, run, edge_ev;
   logic [1:0] bresp, rresp, wid, resp;
   logic [31:0] rdata, rd;
   logic [2:0] op;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int ev_cnt = 0;
   int n;

   tmcc_top uut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .DEBUG_HALT(halt), .FIRST_PWM_RAW(pwm_raw),
      .FIRST_EVENT(first_ev), .SECOND_EDGE_IN(edge_in), .FIRST_PWM_OUT(pwm_out), .ADC_TRIGGER(adc_trig),
      .SECOND_RUN(run), .SECOND_EDGE_EVENT(edge_ev), .SECOND_OP(op), .WIDTH_MODE(wid));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic print_verdict();
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs a few thousand cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (edge_ev === 1'b1) ev_cnt <= ev_cnt + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_sig(input string nm, input logic [2:0] e, input logic [2:0] g);
      chk_data(nm, {29'h0, e}, {29'h0, g});
   endtask

   // Handshakes are judged at the falling edge, where the combinational readies have settled
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_t, w_t;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end while ((awvalid && !aw_t) || (wvalid && !w_t));
      do @(negedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   function automatic logic [1:0] exp_wid(input logic [2:0] c);
      return c[2] ? 2'h2 : (c == 3'h0) ? 2'h0 : (c == 3'h1) ? 2'h1 : 2'h3;
   endfunction

   // Reserved width codes and reserved mode code both leave the second timer off
   function automatic logic [2:0] exp_op(input logic [2:0] c, input logic [3:0] am, input logic [3:0] bm,
      input logic en);
      logic [3:0] m;
      m = (c == 3'h0) ? am : bm;
      if (!en || !(c[2] || c == 3'h0) || m[1:0] == 2'h0) return TMCC_OP_OFF;
      if (m[1:0] == 2'h1) return TMCC_OP_ONESHOT;
      if (m[1:0] == 2'h2) return m[3] ? TMCC_OP_PWM : TMCC_OP_PERIODIC;
      return m[2] ? TMCC_OP_CAPTIME : TMCC_OP_CAPCOUNT;
   endfunction

   task automatic run_mode(input logic [2:0] c, input logic [3:0] am, input logic [3:0] bm, input logic en);
      logic [2:0] e;
      e = exp_op(c, am, bm, en);
      wr(TMCC_CFG_OFF, ({$urandom} & 32'hFFFF_FFF8) | {29'h0, c});
      wr(TMCC_AMODE_OFF, ({$urandom} & 32'hFFFF_FFF0) | {28'h0, am});
      wr(TMCC_BMODE_OFF, ({$urandom} & 32'hFFFF_FFF0) | {28'h0, bm});
      wr(TMCC_CTL_OFF, {23'h0, en, 8'h00});
      repeat (3) @(negedge clk);
      chk_sig("width", {1'b0, exp_wid(c)}, {1'b0, wid});
      chk_sig("op", e, op);
      chk_sig("run", {2'b0, e != 3'h0}, {2'b0, run});
      chk_sig("write resp", 3'h0, {1'b0, resp});
      rd_reg(TMCC_BMODE_OFF);
      chk_data("bmode", {28'h0, bm}, rd);
      chk_sig("read resp", 3'h0, {1'b0, resp});
      rd_reg(TMCC_STAT_OFF);
      chk_data("status", {25'h0, e, exp_wid(c), e != 3'h0, 1'b0}, rd);
   endtask

   initial begin
      void'($urandom(76));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_reg(12'(i * 4));
         chk_data("reset value", 32'h0, rd);
      end
      rd_reg(12'h020);
      chk_data("unmapped rdata", 32'h0, rd);
      chk_sig("unmapped rresp", 3'h2, {1'b0, resp});
      wr(12'h020, 32'hFFFF_FFFF);
      chk_sig("unmapped bresp", 3'h2, {1'b0, resp});
      wr(TMCC_CTL_OFF, 32'hFFFF_FFFF);
      rd_reg(TMCC_CTL_OFF);
      chk_data("control", 32'h0000_0F60, rd);
      // Low byte lane only: the enable, freeze and event fields above it must survive
      wstrb <= 4'h1;
      wr(TMCC_CTL_OFF, 32'h0000_0000);
      wstrb <= 4'hF;
      rd_reg(TMCC_CTL_OFF);
      chk_data("byte lane", 32'h0000_0F00, rd);
      for (int m = 0; m < 16; m++) run_mode(3'h4, 4'(~m), 4'(m), 1'b1);
      for (int m = 0; m < 16; m++) run_mode(3'h0, 4'(m), 4'(~m), 1'b1);
      for (int i = 0; i < 24; i++) run_mode(3'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
      run_mode(3'h1, 4'h1, 4'h1, 1'b1);
      run_mode(3'h2, 4'h2, 4'h2, 1'b1);
      run_mode(3'h5, 4'h0, 4'h2, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(TMCC_CTL_OFF, {22'h0, 1'(i), 1'b1, 8'h00});
         halt <= i[1];
         repeat (6) @(negedge clk);
         chk_sig("run under halt", {2'b0, !(i[0] && i[1])}, {2'b0, run});
         rd_reg(TMCC_STAT_OFF);
         chk_sig("freeze flag", {2'b0, i[0] && i[1]}, {2'b0, rd[0]});
      end
      @(posedge clk);
      halt <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         logic [1:0] r;
         r = 2'($urandom);
         wr(TMCC_CTL_OFF, {25'h0, r, 5'h00});
         pwm_raw <= 1'($urandom);
         first_ev <= 1'($urandom);
         repeat (5) @(negedge clk);
         chk_sig("pwm out", {2'b0, pwm_raw ^ r[1]}, {2'b0, pwm_out});
         chk_sig("adc trigger", {2'b0, first_ev & r[0]}, {2'b0, adc_trig});
      end
      run_mode(3'h4, 4'h0, 4'h3, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(TMCC_CTL_OFF, {20'h0, 2'(i), 10'h100});
         n = ev_cnt;
         edge_in <= 1'b1;
         repeat (8) @(posedge clk);
         edge_in <= 1'b0;
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk_data("edge events", (i == 3) ? 2 : (i == 2) ? 0 : 1, ev_cnt - n);
      end
      print_verdict();
   end
endmodule
